// ==== include/spf_pkg.sv ====
// Constants for the shared pin function select block.
`default_nettype none
package spf_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFF_PIN_SEL = 8'h00;
  localparam logic [7:0] OFF_CKOUT_SEL = 8'h04;
  localparam logic [7:0] OFF_GPIO_DIR = 8'h08;
  localparam logic [7:0] OFF_GPIO_OUT = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_CTRL = 8'h14;

  // Pin select register fields.
  localparam int PB7_FN_LSB = 0;
  localparam int PB4_FN_LSB = 2;
  localparam int PA7_PORT_BIT = 4;

  // Bit positions inside the direction, data, status and control registers.
  localparam int BIT_PB7 = 0;
  localparam int BIT_PB4 = 1;
  localparam int BIT_PA7 = 2;
  localparam int BIT_CAUSE_PIN = 3;
  localparam int BIT_CAUSE_WDOG = 4;
  localparam int BIT_CAUSE_SW = 5;
  localparam int BIT_SW_RESET = 0;

  // Function codes for port B bit 7.
  localparam logic [1:0] PB7_GPIO = 2'h0;
  localparam logic [1:0] PB7_SER = 2'h1;
  localparam logic [1:0] PB7_SCL = 2'h2;

  // Function codes for port B bit 4.
  localparam logic [1:0] PB4_GPIO = 2'h0;
  localparam logic [1:0] PB4_TMR0 = 2'h1;
  localparam logic [1:0] PB4_CKOUT = 2'h2;

  // Clock output source codes.
  localparam logic [1:0] CKOUT_OFF = 2'h0;
  localparam logic [1:0] CKOUT_MSTR = 2'h1;
  localparam logic [1:0] CKOUT_PBUS = 2'h2;
  localparam logic [1:0] CKOUT_OSC = 2'h3;

  // Reset values.
  localparam logic [1:0] PB7_FN_RST = PB7_GPIO;
  localparam logic [1:0] PB4_FN_RST = PB4_GPIO;
  localparam logic PA7_PORT_RST = 1'b0;
  localparam logic [1:0] CKOUT_SEL_RST = CKOUT_OFF;
  localparam logic [2:0] DIR_RST = 3'h0;
  localparam logic [2:0] DOUT_RST = 3'h7;

  // Internal clocks that pass after the last reset source clears.
  localparam int RST_HOLD_CYCLES = 32;
  localparam logic [5:0] RST_HOLD_LAST = 6'(RST_HOLD_CYCLES - 1);

  // Internal reset sequencer states, Gray coded along the path.
  typedef enum logic [1:0] {
    RS_ACTIVE = 2'b00,
    RS_COUNT = 2'b01,
    RS_RUN = 2'b11
  } spf_rst_state_t;
endpackage
`default_nettype wire

// ==== logic/spf_sync3.sv ====
// Three-stage pin synchroniser with an agreement filter.
`timescale 1ns/1ps
`default_nettype none
module spf_sync3 #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // The first stage feeds only the second; the level moves once stages two and three agree.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        q <= s3_q;
    end
  end
endmodule
`default_nettype wire

// ==== logic/spf_top.sv ====
// Shared pin function select with APB registers and internal reset sequencing.
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module spf_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pa7_in,
  output logic pa7_out,
  output logic pa7_oe,
  input wire logic pb7_in,
  output logic pb7_out,
  output logic pb7_oe,
  input wire logic pb4_in,
  output logic pb4_out,
  output logic pb4_oe,
  input wire logic ser_txd,
  input wire logic ser_tx_en,
  input wire logic ser_single_wire,
  output logic ser_rxd,
  input wire logic i2c_scl_low,
  output logic i2c_scl_in,
  input wire logic tmr0_out,
  input wire logic tmr0_oe,
  output logic tmr0_in,
  input wire logic mstr_clk_lvl,
  input wire logic pbus_clk_lvl,
  input wire logic osc_clk_in,
  input wire logic watchdog_reset_source,
  output logic sys_rst_n
);
  logic [1:0] pb7_fn_q;
  logic [1:0] pb4_fn_q;
  logic pa7_port_q;
  logic [1:0] ckout_sel_q;
  logic [2:0] dir_q;
  logic [2:0] dout_q;
  logic [2:0] cause_q;
  logic sw_rst_q;
  logic [5:0] rst_cnt_q;
  logic [5:0] rst_cnt_d;
  spf_pkg::spf_rst_state_t rst_st_q;
  spf_pkg::spf_rst_state_t rst_st_d;
  logic pa7_lvl;
  logic pb7_lvl;
  logic pb4_lvl;
  logic osc_lvl;

  // Every pin level from outside passes the three-stage filter before use.
  spf_sync3 #(.RST_VAL(1'b1)) u_sync_pa7 (
    .clk(pclk),
    .rst_n(presetn),
    .d(pa7_in),
    .q(pa7_lvl)
  );
  spf_sync3 #(.RST_VAL(1'b1)) u_sync_pb7 (
    .clk(pclk),
    .rst_n(presetn),
    .d(pb7_in),
    .q(pb7_lvl)
  );
  spf_sync3 #(.RST_VAL(1'b1)) u_sync_pb4 (
    .clk(pclk),
    .rst_n(presetn),
    .d(pb4_in),
    .q(pb4_lvl)
  );
  spf_sync3 #(.RST_VAL(1'b0)) u_sync_osc (
    .clk(pclk),
    .rst_n(presetn),
    .d(osc_clk_in),
    .q(osc_lvl)
  );

  // APB phase and address decode; the slave answers with no wait state, ready in the first access cycle.
  wire apb_setup = psel & ~penable;
  wire apb_acc = psel & penable & pready;
  wire apb_wr = apb_acc & pwrite;
  wire sel_pin = (paddr == spf_pkg::OFF_PIN_SEL);
  wire sel_ckout = (paddr == spf_pkg::OFF_CKOUT_SEL);
  wire sel_dir = (paddr == spf_pkg::OFF_GPIO_DIR);
  wire sel_out = (paddr == spf_pkg::OFF_GPIO_OUT);
  wire sel_stat = (paddr == spf_pkg::OFF_STATUS);
  wire sel_ctrl = (paddr == spf_pkg::OFF_CTRL);
  wire addr_hit = sel_pin | sel_ckout | sel_dir | sel_out | sel_stat | sel_ctrl;

  // Read data selection; unmapped and write-only words read as zero.
  wire [31:0] rd_pin = {27'h0, pa7_port_q, pb4_fn_q, pb7_fn_q};
  wire [31:0] rd_ckout = {30'h0, ckout_sel_q};
  wire [31:0] rd_dir = {29'h0, dir_q};
  wire [31:0] rd_out = {29'h0, dout_q};
  wire [31:0] rd_stat = {26'h0, cause_q, pa7_lvl, pb4_lvl, pb7_lvl};
  wire [31:0] rd_word = sel_pin ? rd_pin :
                        sel_ckout ? rd_ckout :
                        sel_dir ? rd_dir :
                        sel_out ? rd_out :
                        sel_stat ? rd_stat : 32'h0;

  // Answer registers: ready, data and error are set up during the setup phase.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= apb_setup;
      prdata <= (apb_setup & ~pwrite) ? rd_word : 32'h0;
      pslverr <= apb_setup & ~addr_hit;
    end
  end

  // Write strobes for each register.
  wire wr_pin = apb_wr & sel_pin;
  wire wr_ckout = apb_wr & sel_ckout;
  wire wr_dir = apb_wr & sel_dir;
  wire wr_out = apb_wr & sel_out;
  wire wr_stat = apb_wr & sel_stat;
  wire wr_swrst = apb_wr & sel_ctrl & pwdata[spf_pkg::BIT_SW_RESET];

  // Configuration returns to defaults while the internal reset is active.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pb7_fn_q <= spf_pkg::PB7_FN_RST;
      pb4_fn_q <= spf_pkg::PB4_FN_RST;
      pa7_port_q <= spf_pkg::PA7_PORT_RST;
      ckout_sel_q <= spf_pkg::CKOUT_SEL_RST;
      dir_q <= spf_pkg::DIR_RST;
      dout_q <= spf_pkg::DOUT_RST;
    end
    else if (!sys_rst_n)
    begin
      pb7_fn_q <= spf_pkg::PB7_FN_RST;
      pb4_fn_q <= spf_pkg::PB4_FN_RST;
      pa7_port_q <= spf_pkg::PA7_PORT_RST;
      ckout_sel_q <= spf_pkg::CKOUT_SEL_RST;
      dir_q <= spf_pkg::DIR_RST;
      dout_q <= spf_pkg::DOUT_RST;
    end
    else
    begin
      if (wr_pin)
      begin
        pb7_fn_q <= pwdata[spf_pkg::PB7_FN_LSB +: 2];
        pb4_fn_q <= pwdata[spf_pkg::PB4_FN_LSB +: 2];
        pa7_port_q <= pwdata[spf_pkg::PA7_PORT_BIT];
      end
      if (wr_ckout)
        ckout_sel_q <= pwdata[1:0];
      if (wr_dir)
        dir_q <= pwdata[2:0];
      if (wr_out)
        dout_q <= pwdata[2:0];
    end
  end

  // Reset sources; the pin counts only while it carries its reset function.
  wire pin_rst = ~pa7_lvl & ~pa7_port_q;
  wire rst_src = pin_rst | watchdog_reset_source | sw_rst_q;
  wire [2:0] cause_set = {sw_rst_q, watchdog_reset_source, pin_rst};
  wire [2:0] cause_clr = wr_stat ? pwdata[spf_pkg::BIT_CAUSE_SW:spf_pkg::BIT_CAUSE_PIN] : 3'h0;

  // Software reset pulse and sticky reset causes; a new cause beats a clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sw_rst_q <= 1'b0;
      cause_q <= 3'h0;
    end
    else
    begin
      sw_rst_q <= wr_swrst;
      cause_q <= (cause_q & ~cause_clr) | cause_set;
    end
  end

  // Sequencer holds reset until the sources clear, then counts a fixed delay.
  always_comb
  begin
    rst_st_d = rst_st_q;
    rst_cnt_d = rst_cnt_q;
    unique case (rst_st_q)
      spf_pkg::RS_ACTIVE:
      begin
        rst_cnt_d = 6'h0;
        if (!rst_src)
          rst_st_d = spf_pkg::RS_COUNT;
      end
      spf_pkg::RS_COUNT:
      begin
        if (rst_src)
        begin
          rst_st_d = spf_pkg::RS_ACTIVE;
          rst_cnt_d = 6'h0;
        end
        else if (rst_cnt_q == spf_pkg::RST_HOLD_LAST)
          rst_st_d = spf_pkg::RS_RUN;
        else
          rst_cnt_d = rst_cnt_q + 6'h1;
      end
      spf_pkg::RS_RUN:
      begin
        if (rst_src)
          rst_st_d = spf_pkg::RS_ACTIVE;
      end
      default:
      begin
        rst_st_d = spf_pkg::RS_ACTIVE;
        rst_cnt_d = 6'h0;
      end
    endcase
  end

  // Internal reset leaves on a clock edge, so release is synchronous.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_st_q <= spf_pkg::RS_ACTIVE;
      rst_cnt_q <= 6'h0;
      sys_rst_n <= 1'b0;
    end
    else
    begin
      rst_st_q <= rst_st_d;
      rst_cnt_q <= rst_cnt_d;
      sys_rst_n <= (rst_st_d == spf_pkg::RS_RUN);
    end
  end

  // Clock output source selection.
  wire ckout_lvl = (ckout_sel_q == spf_pkg::CKOUT_MSTR) ? mstr_clk_lvl :
                   (ckout_sel_q == spf_pkg::CKOUT_PBUS) ? pbus_clk_lvl :
                   (ckout_sel_q == spf_pkg::CKOUT_OSC) ? osc_lvl : 1'b0;

  // Port B bit 7: exactly one owner of enable and data; codes 0 and 3 mean GPIO.
  wire pb7_is_ser = (pb7_fn_q == spf_pkg::PB7_SER);
  wire pb7_is_scl = (pb7_fn_q == spf_pkg::PB7_SCL);
  wire ser_oe = ser_single_wire ? ser_tx_en : 1'b1;
  wire pb7_oe_d = pb7_is_ser ? ser_oe :
                  pb7_is_scl ? i2c_scl_low : dir_q[spf_pkg::BIT_PB7];
  wire pb7_out_d = pb7_is_ser ? ser_txd :
                   pb7_is_scl ? 1'b0 : dout_q[spf_pkg::BIT_PB7];

  // Port B bit 4: timer channel zero, clock output or GPIO.
  wire pb4_is_tmr = (pb4_fn_q == spf_pkg::PB4_TMR0);
  wire pb4_is_ckout = (pb4_fn_q == spf_pkg::PB4_CKOUT);
  wire pb4_oe_d = pb4_is_tmr ? tmr0_oe :
                  pb4_is_ckout ? 1'b1 : dir_q[spf_pkg::BIT_PB4];
  wire pb4_out_d = pb4_is_tmr ? tmr0_out :
                   pb4_is_ckout ? ckout_lvl : dout_q[spf_pkg::BIT_PB4];

  // Port A bit 7 only pulls low, and only in port mode.
  wire pa7_oe_d = pa7_port_q & dir_q[spf_pkg::BIT_PA7] & ~dout_q[spf_pkg::BIT_PA7];

  // Peripheral inputs see the pin only when their function owns it.
  wire ser_rxd_d = (pb7_is_ser & ser_single_wire) ? pb7_lvl : 1'b1;
  wire scl_in_d = pb7_is_scl ? pb7_lvl : 1'b1;
  wire tmr0_in_d = pb4_is_tmr ? pb4_lvl : 1'b0;

  // Pin drives and peripheral inputs are registered; pins float during presetn and from the second cycle of internal reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pb7_oe <= 1'b0;
      pb7_out <= 1'b0;
      pb4_oe <= 1'b0;
      pb4_out <= 1'b0;
      pa7_oe <= 1'b0;
      pa7_out <= 1'b0;
      ser_rxd <= 1'b1;
      i2c_scl_in <= 1'b1;
      tmr0_in <= 1'b0;
    end
    else
    begin
      pb7_oe <= pb7_oe_d & sys_rst_n;
      pb7_out <= pb7_out_d;
      pb4_oe <= pb4_oe_d & sys_rst_n;
      pb4_out <= pb4_out_d;
      pa7_oe <= pa7_oe_d & sys_rst_n;
      pa7_out <= 1'b0;
      ser_rxd <= ser_rxd_d;
      i2c_scl_in <= scl_in_d;
      tmr0_in <= tmr0_in_d;
    end
  end
endmodule
`default_nettype wire

// ==== test/spf_top_asserts.sv ====
// Port checker for the shared pin function select block.
`timescale 1ns/1ps
`default_nettype none
module spf_top_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pa7_out,
  input wire logic pa7_oe,
  input wire logic pb7_oe,
  input wire logic pb4_oe,
  input wire logic watchdog_reset_source,
  input wire logic sys_rst_n
);
  logic [5:0] low_q;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Counts cycles spent in internal reset and saturates.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      low_q <= 6'h00;
    else if (sys_rst_n)
      low_q <= 6'h00;
    else if (low_q != 6'h3F)
      low_q <= low_q + 6'h01;
  a_rst_hold_count: assert property ($rose(sys_rst_n) |-> low_q >= 6'h20)
    else $error("internal reset released too early");
  a_wdog_resets: assert property (watchdog_reset_source |-> ##[1:2] !sys_rst_n)
    else $error("watchdog did not reset");
  a_oe_in_reset: assert property (!sys_rst_n && $past(!sys_rst_n) |-> !(pa7_oe | pb7_oe | pb4_oe))
    else $error("pin driven during reset");
  a_release_quiet: assert property ($rose(sys_rst_n) |=> !(pa7_oe | pb7_oe | pb4_oe))
    else $error("pin driven right after reset");
  a_pa7_open_drain: assert property (pa7_oe |-> !pa7_out)
    else $error("port A bit 7 drives high");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("ready outside first access cycle");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_idle: assert property (prdata != 32'h00000000 |-> pready && !pwrite)
    else $error("read data outside read access");
  cover property (pslverr);
  cover property ($rose(sys_rst_n));
  cover property (pb7_oe && pb4_oe);
endmodule
bind spf_top spf_top_asserts spf_top_asserts_inst (.pclk, .presetn, .psel, .penable,
  .pwrite, .prdata, .pready, .pslverr, .pa7_out, .pa7_oe, .pb7_oe, .pb4_oe,
  .watchdog_reset_source, .sys_rst_n);
`default_nettype wire

// ==== test/spf_board.sv ====
// Board model of the three shared pins with pull-ups and outside drivers.
`timescale 1ns/1ps
`default_nettype none
module spf_board (
  input wire logic pa7_oe,
  input wire logic pa7_out,
  input wire logic pb7_oe,
  input wire logic pb7_out,
  input wire logic pb4_oe,
  input wire logic pb4_out,
  input wire logic [2:0] ext_en,
  input wire logic [2:0] ext_val,
  output logic pa7_in,
  output logic pb7_in,
  output logic pb4_in
);
  // Each pin idles high by its pull-up; any driver pulling low wins.
  assign pb7_in = (pb7_oe ? pb7_out : 1'b1) & (ext_en[0] ? ext_val[0] : 1'b1);
  assign pb4_in = (pb4_oe ? pb4_out : 1'b1) & (ext_en[1] ? ext_val[1] : 1'b1);
  assign pa7_in = (pa7_oe ? pa7_out : 1'b1) & (ext_en[2] ? ext_val[2] : 1'b1);
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the shared pin function select block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pa7_in, pa7_out, pa7_oe, pb7_in, pb7_out, pb7_oe, pb4_in, pb4_out, pb4_oe;
  logic ser_txd, ser_tx_en, ser_single_wire, ser_rxd, i2c_scl_low, i2c_scl_in;
  logic tmr0_out, tmr0_oe, tmr0_in, mstr_clk_lvl, pbus_clk_lvl, osc_clk_in;
  logic watchdog_reset_source, sys_rst_n;
  logic [2:0] ext_en, ext_val;
  int bad_count, n_checks, n;
  spf_top spf_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pa7_in, .pa7_out, .pa7_oe, .pb7_in, .pb7_out, .pb7_oe,
    .pb4_in, .pb4_out, .pb4_oe, .ser_txd, .ser_tx_en, .ser_single_wire, .ser_rxd,
    .i2c_scl_low, .i2c_scl_in, .tmr0_out, .tmr0_oe, .tmr0_in, .mstr_clk_lvl,
    .pbus_clk_lvl, .osc_clk_in, .watchdog_reset_source, .sys_rst_n);
  spf_board spf_board_inst (.pa7_oe, .pa7_out, .pb7_oe, .pb7_out, .pb4_oe, .pb4_out,
    .ext_en, .ext_val, .pa7_in, .pb7_in, .pb4_in);
  // Free-running system clock.
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task final_report;
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task lim(input int i);
    if (i >= 200)
    begin
      bad_count++;
      final_report();
    end
  endtask
  // One APB transfer; the request holds until ready is sampled high.
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 200 && pready !== 1'b1; i++) @(posedge pclk);
    lim(i);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task wrst(input logic v);
    for (n = 0; n < 200 && sys_rst_n !== v; n++) @(posedge pclk);
    lim(n);
  endtask
  task t_reset;
    wrst(1'b1);
    chk("hold", 32'(n > spf_pkg::RST_HOLD_CYCLES && n < spf_pkg::RST_HOLD_CYCLES + 4), 1);
    for (int k = 0; k < 4; k++)
    begin
      xfer(1'b0, 8'(4 * k), 0);
      chk("reg", rd, k == 3 ? 32'(spf_pkg::DOUT_RST) : 0);
    end
    chk("oe", 32'({pa7_oe, pb7_oe, pb4_oe}), 0);
    xfer(1'b0, 8'h3C, 0);
    chk("unmapped_rd", rd, 0);
    chk("unmapped_err", 32'(err), 1);
  endtask
  task t_gpio;
    xfer(1'b1, spf_pkg::OFF_GPIO_DIR, 3);
    xfer(1'b1, spf_pkg::OFF_GPIO_OUT, 2);
    cyc(2);
    chk("pb_drive", 32'({pb7_oe, pb4_oe, pb7_out, pb4_out}), 32'h0000000D);
    xfer(1'b1, spf_pkg::OFF_GPIO_DIR, 2);
    {ext_en[0], ext_val[0]} <= 2'b10;
    cyc(8);
    xfer(1'b0, spf_pkg::OFF_STATUS, 0);
    chk("pb_levels", 32'({pb7_oe, rd[1:0]}), 2);
    ext_en <= 3'h0;
  endtask
  task t_ser;
    xfer(1'b1, spf_pkg::OFF_PIN_SEL, 32'(spf_pkg::PB7_SER));
    {ser_txd, ser_tx_en} <= 2'b11;
    cyc(3);
    chk("tx", 32'({pb7_oe, pb7_out, i2c_scl_in}), 7);
    {ser_single_wire, ser_tx_en, ext_en[0], ext_val[0]} <= 4'hA;
    cyc(8);
    chk("rx", 32'({pb7_oe, ser_rxd}), 0);
    xfer(1'b1, spf_pkg::OFF_PIN_SEL, 32'(spf_pkg::PB7_SCL));
    i2c_scl_low <= 1'b1;
    cyc(8);
    chk("scl", 32'({pb7_oe, pb7_out, i2c_scl_in, ser_rxd}), 9);
    {i2c_scl_low, ext_en} <= 4'h0;
  endtask
  // The timer drives the pin low; its input reads 0 then, the same as when timer zero does not own the pin.
  task t_ckout;
    logic [2:0] m;
    xfer(1'b1, spf_pkg::OFF_PIN_SEL, 32'(spf_pkg::PB4_TMR0) << spf_pkg::PB4_FN_LSB);
    {tmr0_oe, tmr0_out} <= 2'b10;
    cyc(8);
    chk("tmr", 32'({pb4_oe, pb4_out, tmr0_in}), 4);
    xfer(1'b1, spf_pkg::OFF_PIN_SEL, 32'(spf_pkg::PB4_CKOUT) << spf_pkg::PB4_FN_LSB);
    for (int s = 0; s < 4; s++)
    begin
      xfer(1'b1, spf_pkg::OFF_CKOUT_SEL, s);
      m = (s == 0) ? 3'h0 : 3'(1 << (s - 1));
      for (int v = 0; v < 2; v++)
      begin
        {osc_clk_in, pbus_clk_lvl, mstr_clk_lvl} <= v ? m : ~m;
        cyc(8);
        chk("ckout", 32'({pb4_oe, pb4_out}), s == 0 ? 2 : 2 + v);
      end
    end
  endtask
  task t_pin;
    {ext_en[2], ext_val[2]} <= 2'b10;
    wrst(1'b0);
    cyc(20);
    chk("pin_hold", 32'(sys_rst_n), 0);
    ext_en <= 3'h0;
    wrst(1'b1);
    xfer(1'b0, spf_pkg::OFF_PIN_SEL, 0);
    chk("sel_clr", rd, 0);
    xfer(1'b1, spf_pkg::OFF_PIN_SEL, 1 << spf_pkg::PA7_PORT_BIT);
    xfer(1'b1, spf_pkg::OFF_GPIO_DIR, 4);
    xfer(1'b1, spf_pkg::OFF_GPIO_OUT, 0);
    cyc(20);
    chk("port_mode", 32'({pa7_oe, sys_rst_n}), 3);
    watchdog_reset_source <= 1'b1;
    cyc(1);
    watchdog_reset_source <= 1'b0;
    wrst(1'b0);
    wrst(1'b1);
    xfer(1'b0, spf_pkg::OFF_PIN_SEL, 0);
    chk("wdog_clr", rd, 0);
    chk("wdog_oe", 32'(pa7_oe), 0);
  endtask
  // Reset causes and their clear, code 3 as port, unmapped write, software reset.
  task t_cause;
    xfer(1'b0, spf_pkg::OFF_STATUS, 0);
    chk("cause", rd & 32'h00000038, 32'h00000018);
    xfer(1'b1, spf_pkg::OFF_STATUS, 32'h00000038);
    xfer(1'b0, spf_pkg::OFF_STATUS, 0);
    chk("cause_clr", rd & 32'h00000038, 32'h00000000);
    xfer(1'b1, spf_pkg::OFF_PIN_SEL, 32'h0000000F);
    xfer(1'b1, spf_pkg::OFF_GPIO_DIR, 3);
    xfer(1'b1, spf_pkg::OFF_GPIO_OUT, 3);
    cyc(2);
    chk("code3_port", 32'({pb7_oe, pb4_oe, pb7_out, pb4_out}), 15);
    xfer(1'b1, 8'h3C, 32'h00000001);
    chk("wr_unmapped", 32'(err), 1);
    xfer(1'b1, spf_pkg::OFF_CTRL, 32'h00000001);
    wrst(1'b0);
    wrst(1'b1);
    chk("sw_hold", 32'(n > spf_pkg::RST_HOLD_CYCLES && n < spf_pkg::RST_HOLD_CYCLES + 4), 1);
    xfer(1'b0, spf_pkg::OFF_STATUS, 0);
    chk("sw_cause", rd & 32'h00000038, 32'h00000020);
    xfer(1'b0, spf_pkg::OFF_PIN_SEL, 0);
    chk("sw_defaults", rd, 0);
    chk("sw_oe", 32'({pa7_oe, pb7_oe, pb4_oe}), 0);
  endtask
  // Main sequence.
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ext_en, ext_val} = '0;
    {ser_txd, ser_tx_en, ser_single_wire, i2c_scl_low, tmr0_out, tmr0_oe} = '0;
    {mstr_clk_lvl, pbus_clk_lvl, osc_clk_in, watchdog_reset_source} = '0;
    bad_count = 0;
    n_checks = 0;
    cyc(8);
    presetn <= 1'b1;
    t_reset();
    t_gpio();
    t_ser();
    t_ckout();
    t_pin();
    t_cause();
    final_report();
  end
endmodule
`default_nettype wire
